// *** sp_map.vh ***
`ifndef SP_MAP_VH
`define SP_MAP_VH
// Contract
// - Mode 0 gives eight clocks, byte LSB first
// - Mode 0 shifts at last phase, osc/12
// - Bit 0 out next cycle, clock low S3P1
// - MSB in cycle nine, then pin high, done
// - Receive: clock low S3P1, sample at S5P2
// - After eight shifts set receive flag, load buffer
// - Buffer write transmits, buffer read returns received
// - Second received byte overwrites unread first
// - Both done flags share one interrupt request
// - Async transmit and receive run independently
// - Mode 1 ten-bit frame, stop into ninth
// - Modes 2/3 eleven bits with ninth bit
// - Mode 2 rate osc/32 or osc/64
// - Modes 1/3 rate from timer overflows
// - Async receive starts on falling edge
// - Missing stop bit sets framing error
// - Framing error sticks until firmware clears
// - Filter drops frames with ninth bit zero
// - Address frames accepted only on match
// - Given address compares under mask ones
// - Broadcast address is address OR mask
// - Filter enable ignored in mode 0
// - Address and mask reset to zero
`define SP_ADDR_W 12
`define SP_IDX_CTRL 10'h098
`define SP_IDX_BUF 10'h099
`define SP_IDX_SLAVE_ADDRESS 10'h0a9
`define SP_IDX_SMASK 10'h0b9
`define SP_IDX_PWR 10'h0c7
`define SP_CTRL_RST 8'h00
`define SP_SLAVE_ADDRESS_RST 8'h00
`define SP_SMASK_RST 8'h00
`define SP_PWR_RST 8'h00
`define SP_RESP_OKAY 2'b00
`define SP_B_MSH 7
`define SP_B_MSL 6
`define SP_B_MPE 5
`define SP_B_REN 4
`define SP_B_TB8 3
`define SP_B_RB8 2
`define SP_B_TI 1
`define SP_B_RI 0
`define SP_B_RDBL 7
`define SP_B_FCHK 6
`define SP_B_RXT2 1
`define SP_B_TXT2 0
`define SP_MODE0 2'b00
`define SP_MODE1 2'b01
`define SP_MODE2 2'b10
`define SP_MODE3 2'b11
`define SP_PH_S1P1 4'd0
`define SP_PH_S3P1 4'd4
`define SP_PH_S5P2 4'd9
`define SP_PH_LAST 4'd11
`define SP_M0_DFIRST 4'd1
`define SP_M0_DLAST 4'd8
`define SP_M0_FIRST 4'd2
`define SP_M0_LAST 4'd9
`define SP_M0_END 4'd10
`define SP_OVS_MID 4'd7
`define SP_M2_DIV_SLOW 2'd3
`define SP_M2_DIV_FAST 2'd1
`define SP_OVF_DIV_SLOW 2'd1
`define SP_OVF_DIV_FAST 2'd0
`define SP_TX_LEFT_M1 4'd9
`define SP_TX_LEFT_M23 4'd10
`define SP_RX_LAST_M1 4'd9
`define SP_RX_LAST_M23 4'd10
`endif

// *** sp_sync3.v ***
`timescale 1ns/1ps
module sp_sync3 #(
  parameter RST_VAL = 1'b1
) (
  input wire clk_i,
  input wire srst_i,
  input wire d_i,
  output reg q_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Level changes only once the two later stages agree
  always @(posedge clk_i) begin
    if (srst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_o <= s3_r;
      end
    end
  end
endmodule

// *** sp_axil.v ***
`timescale 1ns/1ps
`include "sp_map.vh"
module sp_axil (
  input wire clk_i,
  input wire srst_i,
  input wire awvalid_i,
  output reg awready_o,
  input wire [`SP_ADDR_W-1:0] awaddr_i,
  input wire wvalid_i,
  output reg wready_o,
  input wire [31:0] wdata_i,
  input wire [3:0] wstrb_i,
  output reg bvalid_o,
  input wire bready_i,
  output reg [1:0] bresp_o,
  input wire arvalid_i,
  output reg arready_o,
  input wire [`SP_ADDR_W-1:0] araddr_i,
  output reg rvalid_o,
  input wire rready_i,
  output reg [31:0] rdata_o,
  output reg [1:0] rresp_o,
  output reg wr_stb_o,
  output reg [9:0] wr_idx_o,
  output reg [7:0] wr_data_o,
  output wire [9:0] rd_idx_o,
  input wire [7:0] rd_data_i
);
  reg wen_r;

  assign rd_idx_o = araddr_i[`SP_ADDR_W-1:2];

  ////////////////////////////////////////////////////////////////////////////
  // Write: address and data taken in either order, one write in flight
  always @(posedge clk_i) begin
    if (srst_i) begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      bvalid_o <= 1'b0;
      bresp_o <= `SP_RESP_OKAY;
      wr_stb_o <= 1'b0;
      wr_idx_o <= 10'h000;
      wr_data_o <= 8'h00;
      wen_r <= 1'b0;
    end else begin
      wr_stb_o <= 1'b0;
      if (awvalid_i && awready_o) begin
        wr_idx_o <= awaddr_i[`SP_ADDR_W-1:2];
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        wr_data_o <= wdata_i[7:0];
        wen_r <= wstrb_i[0];
        wready_o <= 1'b0;
      end
      // Registers live in byte lane 0; other lanes are ignored
      if (!awready_o && !wready_o && !bvalid_o) begin
        wr_stb_o <= wen_r;
        bvalid_o <= 1'b1;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read: data sampled at the address handshake
  always @(posedge clk_i) begin
    if (srst_i) begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h00000000;
      rresp_o <= `SP_RESP_OKAY;
    end else begin
      if (arvalid_i && arready_o) begin
        arready_o <= 1'b0;
        rvalid_o <= 1'b1;
        rdata_o <= {24'h000000, rd_data_i};
      end
      if (rvalid_o && rready_i) begin
        rvalid_o <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end
endmodule

// *** sp_top.v ***
`timescale 1ns/1ps
`include "sp_map.vh"
module sp_top (
  input wire CLK_I,
  input wire SRST_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [`SP_ADDR_W-1:0] AWADDR_I,
  input wire WVALID_I,
  output wire WREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  output wire BVALID_O,
  input wire BREADY_I,
  output wire [1:0] BRESP_O,
  input wire ARVALID_I,
  output wire ARREADY_O,
  input wire [`SP_ADDR_W-1:0] ARADDR_I,
  output wire RVALID_O,
  input wire RREADY_I,
  output wire [31:0] RDATA_O,
  output wire [1:0] RRESP_O,
  input wire T1_OVF_I,
  input wire T2_OVF_I,
  output wire TXD_O,
  input wire RXD_I,
  output wire RXD_O,
  output wire RXD_OE_O,
  output wire SERIAL_IRQ_O
);
  wire wr_stb;
  wire [9:0] wr_idx;
  wire [7:0] wr_data;
  wire [9:0] rd_idx;
  reg [7:0] rd_data;
  wire rxd_s;

  reg [1:0] mode_r;
  reg mpe_r;
  reg ren_r;
  reg tb8_r;
  reg rb8_r;
  reg ti_r;
  reg ri_r;
  reg fe_r;
  reg fchk_r;
  reg rdbl_r;
  reg rxt2_r;
  reg txt2_r;
  reg [7:0] slave_address_r;
  reg [7:0] smask_r;
  reg [7:0] rx_hold_r;
  reg [3:0] ph_r;
  reg irq_r;
  reg txd_r;
  reg ti_nxt;
  reg ri_nxt;
  reg fe_nxt;
  reg rb8_nxt;

  reg m0_arm_r;
  reg m0_busy_r;
  reg m0_rx_r;
  reg [3:0] m0_cnt_r;
  reg [7:0] m0_sh_r;
  reg m0_bit_r;
  reg m0_rxd_r;
  reg m0_oe_r;

  reg [1:0] tx_pre_r;
  reg [1:0] rx_pre_r;
  reg atx_busy_r;
  reg [3:0] atx_cnt_r;
  reg [3:0] atx_left_r;
  reg [9:0] atx_sh_r;
  reg atx_line_r;
  reg arx_busy_r;
  reg [3:0] arx_cnt_r;
  reg [3:0] arx_idx_r;
  reg [9:0] arx_sh_r;
  reg rx_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by both directions and the address filter

  function addr_match;
    input [7:0] a;
    input [7:0] sa;
    input [7:0] sm;
    reg [7:0] bc;
    begin
      bc = sa | sm;
      addr_match = (((a ^ sa) & sm) == 8'h00) ||
                   (((a ^ bc) & bc) == 8'h00);
    end
  endfunction

  // Overflow or clock pulses per 1/16 bit, minus one
  function [1:0] tick_lim;
    input [1:0] mode;
    input dbl;
    begin
      if (mode == `SP_MODE2) begin
        tick_lim = dbl ? `SP_M2_DIV_FAST : `SP_M2_DIV_SLOW;
      end else begin
        tick_lim = dbl ? `SP_OVF_DIV_FAST : `SP_OVF_DIV_SLOW;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and pin synchroniser

  sp_axil u_axil (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .awvalid_i(AWVALID_I),
    .awready_o(AWREADY_O),
    .awaddr_i(AWADDR_I),
    .wvalid_i(WVALID_I),
    .wready_o(WREADY_O),
    .wdata_i(WDATA_I),
    .wstrb_i(WSTRB_I),
    .bvalid_o(BVALID_O),
    .bready_i(BREADY_I),
    .bresp_o(BRESP_O),
    .arvalid_i(ARVALID_I),
    .arready_o(ARREADY_O),
    .araddr_i(ARADDR_I),
    .rvalid_o(RVALID_O),
    .rready_i(RREADY_I),
    .rdata_o(RDATA_O),
    .rresp_o(RRESP_O),
    .wr_stb_o(wr_stb),
    .wr_idx_o(wr_idx),
    .wr_data_o(wr_data),
    .rd_idx_o(rd_idx),
    .rd_data_i(rd_data)
  );

  sp_sync3 #(
    .RST_VAL(1'b1)
  ) u_rxd_sync (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .d_i(RXD_I),
    .q_o(rxd_s)
  );

  wire wr_ctrl = wr_stb && (wr_idx == `SP_IDX_CTRL);
  wire wr_buf = wr_stb && (wr_idx == `SP_IDX_BUF);
  wire async_mode = (mode_r != `SP_MODE0);

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral cycle: twelve phases, S1P1 = 0 .. S6P2 = 11

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      ph_r <= `SP_PH_S1P1;
    end else if (ph_r == `SP_PH_LAST) begin
      ph_r <= `SP_PH_S1P1;
    end else begin
      ph_r <= ph_r + 4'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode 0 shifter, shared by transmit and receive (half duplex)

  wire m0_rx_go = wr_ctrl && !wr_data[`SP_B_MSH] && !wr_data[`SP_B_MSL] &&
                  !wr_data[`SP_B_RI] && wr_data[`SP_B_REN];
  wire m0_tx_go = wr_buf && !async_mode;
  wire m0_done = m0_busy_r && (ph_r == `SP_PH_S1P1) &&
                 (m0_cnt_r == `SP_M0_END);
  wire m0_pulse = m0_busy_r && (m0_cnt_r >= `SP_M0_FIRST) &&
                  (m0_cnt_r <= `SP_M0_LAST) && (ph_r >= `SP_PH_S3P1) &&
                  (ph_r <= `SP_PH_S5P2);

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      m0_arm_r <= 1'b0;
      m0_busy_r <= 1'b0;
      m0_rx_r <= 1'b0;
      m0_cnt_r <= 4'd0;
      m0_sh_r <= 8'h00;
      m0_bit_r <= 1'b0;
      m0_rxd_r <= 1'b1;
      m0_oe_r <= 1'b0;
    end else begin
      if ((m0_tx_go || m0_rx_go) && !m0_busy_r && !m0_arm_r) begin
        m0_arm_r <= 1'b1;
        m0_rx_r <= m0_rx_go;
        if (m0_tx_go) begin
          m0_sh_r <= wr_data;
        end
      end else if (m0_arm_r && ph_r == `SP_PH_LAST) begin
        // The write takes effect at the end of this peripheral cycle
        m0_arm_r <= 1'b0;
        m0_busy_r <= 1'b1;
        m0_cnt_r <= `SP_M0_DFIRST;
        if (m0_rx_r) begin
          m0_oe_r <= 1'b0;
        end
      end else if (m0_busy_r) begin
        if (ph_r == `SP_PH_S5P2) begin
          m0_bit_r <= rxd_s;
        end
        if (ph_r == `SP_PH_LAST) begin
          m0_cnt_r <= m0_cnt_r + 4'd1;
          if (!m0_rx_r && m0_cnt_r >= `SP_M0_DFIRST &&
              m0_cnt_r <= `SP_M0_DLAST) begin
            m0_rxd_r <= m0_sh_r[0];
            m0_oe_r <= 1'b1;
            m0_sh_r <= {1'b0, m0_sh_r[7:1]};
          end
          if (m0_rx_r && m0_cnt_r >= `SP_M0_FIRST &&
              m0_cnt_r <= `SP_M0_LAST) begin
            m0_sh_r <= {m0_bit_r, m0_sh_r[7:1]};
          end
        end
        if (m0_done) begin
          m0_busy_r <= 1'b0;
          if (!m0_rx_r) begin
            m0_rxd_r <= 1'b1;
            m0_oe_r <= 1'b1;
          end
        end
      end
      // The data pin is an input whenever an async mode is selected
      if (async_mode) begin
        m0_oe_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Async bit-rate ticks, sixteen per bit, one generator per direction

  wire tx_src = (mode_r == `SP_MODE2) ? 1'b1 :
                (txt2_r ? T2_OVF_I : T1_OVF_I);
  wire rx_src = (mode_r == `SP_MODE2) ? 1'b1 :
                (rxt2_r ? T2_OVF_I : T1_OVF_I);
  wire tx_tick = tx_src && (tx_pre_r == tick_lim(mode_r, rdbl_r));
  wire rx_tick = rx_src && (rx_pre_r == tick_lim(mode_r, rdbl_r));

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      tx_pre_r <= 2'd0;
      rx_pre_r <= 2'd0;
    end else begin
      if (tx_src) begin
        tx_pre_r <= tx_tick ? 2'd0 : tx_pre_r + 2'd1;
      end
      if (rx_src) begin
        rx_pre_r <= rx_tick ? 2'd0 : rx_pre_r + 2'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Async transmitter

  wire atx_ninth = (mode_r == `SP_MODE1) ? 1'b1 : tb8_r;
  wire atx_done = atx_busy_r && tx_tick && (atx_cnt_r == 4'd15) &&
                  (atx_left_r == 4'd0);

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      atx_busy_r <= 1'b0;
      atx_cnt_r <= 4'd0;
      atx_left_r <= 4'd0;
      atx_sh_r <= 10'h3ff;
      atx_line_r <= 1'b1;
    end else if (wr_buf && async_mode && !atx_busy_r) begin
      atx_busy_r <= 1'b1;
      atx_cnt_r <= 4'd0;
      atx_line_r <= 1'b0;
      atx_sh_r <= {1'b1, atx_ninth, wr_data};
      atx_left_r <= (mode_r == `SP_MODE1) ? `SP_TX_LEFT_M1 :
                    `SP_TX_LEFT_M23;
    end else if (atx_busy_r && tx_tick) begin
      atx_cnt_r <= atx_cnt_r + 4'd1;
      if (atx_cnt_r == 4'd15) begin
        if (atx_left_r == 4'd0) begin
          atx_busy_r <= 1'b0;
        end else begin
          atx_line_r <= atx_sh_r[0];
          atx_sh_r <= {1'b1, atx_sh_r[9:1]};
          atx_left_r <= atx_left_r - 4'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Async receiver, samples each bit at its middle tick

  wire [3:0] arx_last = (mode_r == `SP_MODE1) ? `SP_RX_LAST_M1 :
                        `SP_RX_LAST_M23;
  wire [9:0] arx_full = {rxd_s, arx_sh_r[9:1]};
  wire arx_end = arx_busy_r && rx_tick && (arx_cnt_r == `SP_OVS_MID) &&
                 (arx_idx_r == arx_last);
  wire [7:0] arx_data = (mode_r == `SP_MODE1) ? arx_full[8:1] :
                        arx_full[7:0];
  wire arx_ninth = (mode_r == `SP_MODE1) ? arx_full[9] : arx_full[8];
  wire arx_stop = arx_full[9];
  wire arx_acc = arx_end && (!mpe_r ||
                 (arx_ninth && addr_match(arx_data, slave_address_r, smask_r)));
  wire fe_set = arx_end && fchk_r && !arx_stop;

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      arx_busy_r <= 1'b0;
      arx_cnt_r <= 4'd0;
      arx_idx_r <= 4'd0;
      arx_sh_r <= 10'h000;
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= rxd_s;
      if (!arx_busy_r) begin
        if (ren_r && async_mode && rx_prev_r && !rxd_s) begin
          arx_busy_r <= 1'b1;
          arx_cnt_r <= 4'd0;
          arx_idx_r <= 4'd0;
        end
      end else if (rx_tick) begin
        arx_cnt_r <= arx_cnt_r + 4'd1;
        if (arx_cnt_r == `SP_OVS_MID) begin
          arx_idx_r <= arx_idx_r + 4'd1;
          if (arx_idx_r == 4'd0) begin
            // A start bit that is high again is only a glitch
            if (rxd_s) begin
              arx_busy_r <= 1'b0;
            end
          end else begin
            arx_sh_r <= arx_full;
          end
          if (arx_end) begin
            arx_busy_r <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: a hardware set wins over a firmware clear

  always @* begin
    ti_nxt = wr_ctrl ? wr_data[`SP_B_TI] : ti_r;
    ri_nxt = wr_ctrl ? wr_data[`SP_B_RI] : ri_r;
    fe_nxt = (wr_ctrl && fchk_r) ? wr_data[`SP_B_MSH] : fe_r;
    rb8_nxt = wr_ctrl ? wr_data[`SP_B_RB8] : rb8_r;
    if (m0_done && !m0_rx_r) begin
      ti_nxt = 1'b1;
    end
    if (atx_done) begin
      ti_nxt = 1'b1;
    end
    if (m0_done && m0_rx_r) begin
      ri_nxt = 1'b1;
    end
    if (arx_acc) begin
      ri_nxt = 1'b1;
      rb8_nxt = arx_ninth;
    end
    if (fe_set) begin
      fe_nxt = 1'b1;
    end
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      mode_r <= `SP_MODE0;
      mpe_r <= 1'b0;
      ren_r <= 1'b0;
      tb8_r <= 1'b0;
      rb8_r <= 1'b0;
      ti_r <= 1'b0;
      ri_r <= 1'b0;
      fe_r <= 1'b0;
      fchk_r <= 1'b0;
      rdbl_r <= 1'b0;
      rxt2_r <= 1'b0;
      txt2_r <= 1'b0;
      slave_address_r <= `SP_SLAVE_ADDRESS_RST;
      smask_r <= `SP_SMASK_RST;
      rx_hold_r <= 8'h00;
      irq_r <= 1'b0;
      txd_r <= 1'b1;
    end else begin
      ti_r <= ti_nxt;
      ri_r <= ri_nxt;
      fe_r <= fe_nxt;
      rb8_r <= rb8_nxt;
      if (wr_ctrl) begin
        // Bit 7 reaches the framing flag while checking is enabled
        if (!fchk_r) begin
          mode_r[1] <= wr_data[`SP_B_MSH];
        end
        mode_r[0] <= wr_data[`SP_B_MSL];
        mpe_r <= wr_data[`SP_B_MPE];
        ren_r <= wr_data[`SP_B_REN];
        tb8_r <= wr_data[`SP_B_TB8];
      end
      if (wr_stb && wr_idx == `SP_IDX_PWR) begin
        rdbl_r <= wr_data[`SP_B_RDBL];
        fchk_r <= wr_data[`SP_B_FCHK];
        rxt2_r <= wr_data[`SP_B_RXT2];
        txt2_r <= wr_data[`SP_B_TXT2];
      end
      if (wr_stb && wr_idx == `SP_IDX_SLAVE_ADDRESS) begin
        slave_address_r <= wr_data;
      end
      if (wr_stb && wr_idx == `SP_IDX_SMASK) begin
        smask_r <= wr_data;
      end
      // A completed byte replaces any unread one
      if (m0_done && m0_rx_r) begin
        rx_hold_r <= m0_sh_r;
      end else if (arx_acc) begin
        rx_hold_r <= arx_data;
      end
      irq_r <= ti_r | ri_r;
      txd_r <= async_mode ? atx_line_r : !m0_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read map; unmapped words read as zero

  always @* begin
    case (rd_idx)
      `SP_IDX_CTRL: rd_data = {fchk_r ? fe_r : mode_r[1], mode_r[0],
                               mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
      `SP_IDX_BUF: rd_data = rx_hold_r;
      `SP_IDX_SLAVE_ADDRESS: rd_data = slave_address_r;
      `SP_IDX_SMASK: rd_data = smask_r;
      `SP_IDX_PWR: rd_data = {rdbl_r, fchk_r, 4'h0, rxt2_r, txt2_r};
      default: rd_data = 8'h00;
    endcase
  end

  assign TXD_O = txd_r;
  assign RXD_O = m0_rxd_r;
  assign RXD_OE_O = m0_oe_r;
  assign SERIAL_IRQ_O = irq_r;
endmodule

// *** sp_top_asserts.sv ***
`timescale 1ns/1ps
`include "sp_map.vh"
module sp_top_chk (
  input logic CLK_I,
  input logic SRST_I,
  input logic AWVALID_I,
  input logic AWREADY_O,
  input logic WVALID_I,
  input logic WREADY_O,
  input logic BVALID_O,
  input logic BREADY_I,
  input logic [1:0] BRESP_O,
  input logic ARVALID_I,
  input logic ARREADY_O,
  input logic [11:0] ARADDR_I,
  input logic RVALID_O,
  input logic RREADY_I,
  input logic [31:0] RDATA_O,
  input logic [1:0] RRESP_O,
  input logic TXD_O,
  input logic RXD_O,
  input logic RXD_OE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  logic rd_ctrl_r;
  always @(posedge CLK_I) begin
    if (SRST_I) rd_ctrl_r <= 1'b0;
    else if (ARVALID_I && ARREADY_O)
      rd_ctrl_r <= ARADDR_I == {`SP_IDX_CTRL, 2'b00};
  end
  ////////////////////////////////////////////////////////////////////////
  property p_clk_low;
    $fell(TXD_O) && RXD_OE_O |-> !TXD_O [*6] ##1 TXD_O;
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("shift clock low time wrong");
  property p_clk_high;
    $rose(TXD_O) && RXD_OE_O |-> TXD_O [*6];
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("shift clock high time wrong");
  property p_data_hold;
    RXD_OE_O && !TXD_O |-> $stable(RXD_O);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data pin moved while shift clock low");
  property p_bhold;
    BVALID_O && !BREADY_I |=> BVALID_O;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rhold;
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped or changed");
  property p_rpad;
    RVALID_O |-> RDATA_O[31:8] == 24'h0 && RRESP_O == 2'b00;
  endproperty
  a_rpad: assert property (p_rpad)
    else $error("read word upper bits or response wrong");
  // Both halves are registered first, the strobe and response follow
  property p_wr_ans;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
      |=> !AWREADY_O && !WREADY_O && !BVALID_O
      ##1 BVALID_O && BRESP_O == 2'b00 && !AWREADY_O;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write not answered in time");
  property p_rd_ans;
    ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered next cycle");
  // Only the synchronous mode may drive the data pin
  property p_m0_owner;
    RVALID_O && rd_ctrl_r && RXD_OE_O |-> !RDATA_O[`SP_B_MSL];
  endproperty
  a_m0_owner: assert property (p_m0_owner)
    else $error("data pin driven outside the synchronous mode");
endmodule

bind sp_top sp_top_chk u_chk (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .AWVALID_I(AWVALID_I),
  .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .BRESP_O(BRESP_O),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .ARADDR_I(ARADDR_I),
  .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .RDATA_O(RDATA_O),
  .RRESP_O(RRESP_O), .TXD_O(TXD_O), .RXD_O(RXD_O), .RXD_OE_O(RXD_OE_O)
);

// *** sp_peer.sv ***
`timescale 1ns/1ps
module sp_peer (
  input logic clk_i,
  input logic txd_i,
  output logic rxd_o
);
  logic line = 1'b1;
  logic m0_on = 1'b0;
  logic pt = 1'b1;
  logic [7:0] sh = 8'h00;
  assign rxd_o = m0_on ? sh[0] : line;
  // Expander moves on after each rising shift clock; spent bits invert
  always @(posedge clk_i) begin
    pt <= txd_i;
    if (m0_on && txd_i && !pt) sh <= {~sh[0], sh[7:1]};
  end
  task m0(input logic [7:0] d);
    @(posedge clk_i);
    sh <= d;
    m0_on <= d[0] | 1'b1;
  endtask
  task m0_off;
    @(posedge clk_i);
    m0_on <= 1'b0;
  endtask
  task send(input logic [10:0] b, input int nb, input int per);
    for (int k = 0; k < nb; k++) begin
      @(posedge clk_i);
      line <= b[k];
      repeat (per - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    line <= 1'b1;
  endtask
  // Samples mid-bit from the start edge, LSB first
  task recv(input int nb, input int per, output logic [10:0] b);
    b = 11'h0;
    while (txd_i) @(posedge clk_i);
    repeat (per / 2) @(posedge clk_i);
    for (int k = 0; k < nb; k++) begin
      b[k] = txd_i;
      repeat (per) @(posedge clk_i);
    end
  endtask
endmodule

// *** sp_top_test.sv ***
`timescale 1ns/1ps
`include "sp_map.vh"
module sp_top_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic t1 = 1'b0, t2 = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, seed = 32'd49;
  wire awr, wrd, bv, arr, rv, txd, rxdo, oe, irq, prx;
  wire [1:0] bresp, rresp;
  wire [31:0] rdat;
  wire rxd = oe ? rxdo : prx;
  int bad_count = 0, checked = 0, cyc = 0, n, i;
  logic [7:0] d, e, v, a;
  logic [10:0] fb;
  logic pt, t9, r9, ok;
  logic [7:0] q[$];
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    t1 <= cyc % 2 == 0;
    t2 <= cyc % 4 == 0;
  end
  sp_top u_dut (.CLK_I(clk), .SRST_I(srst), .AWVALID_I(awv),
    .AWREADY_O(awr), .AWADDR_I(awa), .WVALID_I(wv), .WREADY_O(wrd),
    .WDATA_I(wd), .WSTRB_I(4'hf), .BVALID_O(bv), .BREADY_I(bre),
    .BRESP_O(bresp), .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara),
    .RVALID_O(rv), .RREADY_I(rre), .RDATA_O(rdat), .RRESP_O(rresp),
    .T1_OVF_I(t1), .T2_OVF_I(t2), .TXD_O(txd), .RXD_I(rxd),
    .RXD_O(rxdo), .RXD_OE_O(oe), .SERIAL_IRQ_O(irq));
  sp_peer u_peer (.clk_i(clk), .txd_i(txd), .rxd_o(prx));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checked++;
    if (got !== ex) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task wr(input logic [9:0] x, input logic [7:0] dd);
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= {x, 2'b00};
    wd <= {24'h0, dd};
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    bre <= 1'b0;
  endtask
  task rd(input logic [9:0] x, output logic [7:0] r);
    @(posedge clk);
    arv <= 1'b1;
    ara <= {x, 2'b00};
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rre <= 1'b0;
    r = rdat[7:0];
  endtask
  task end_sim;
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(`SP_IDX_SLAVE_ADDRESS, v); chk("slave_address", 8'h00, v);
    rd(`SP_IDX_SMASK, v); chk("smask", 8'h00, v);
    rd(10'h3ff, v); chk("unmapped", 8'h00, v);
    wr(`SP_IDX_CTRL, 8'h00);
    d = rnd();
    wr(`SP_IDX_BUF, d);
    n = 0;
    pt = 1'b1;
    repeat (150) begin
      @(posedge clk);
      if (pt && !txd) begin
        v = {rxdo, v[7:1]};
        n++;
      end
      pt = txd;
    end
    chk("m0 clocks", 8, n[7:0]);
    chk("m0 tx byte", d, v);
    chk("m0 end level", 1, rxdo);
    rd(`SP_IDX_CTRL, v); chk("m0 flags", 8'h02, v);
    chk("irq", 1, irq);
    d = rnd();
    u_peer.m0(d);
    wr(`SP_IDX_CTRL, 8'h30);
    repeat (200) @(posedge clk);
    rd(`SP_IDX_CTRL, v); chk("m0 rx flag", 1, v[0]);
    rd(`SP_IDX_BUF, v); chk("m0 rx byte", d, v);
    u_peer.m0_off();
    d = rnd();
    e = rnd();
    t9 = rnd() > 127;
    r9 = rnd() > 127;
    wr(`SP_IDX_PWR, 8'h82);
    wr(`SP_IDX_CTRL, 8'hd0 | {t9, 3'b0});
    wr(`SP_IDX_BUF, d);
    fork
      u_peer.recv(11, 32, fb);
      u_peer.send({1'b1, r9, e, 1'b0}, 11, 64);
    join
    chk("m3 tx byte", d, fb[8:1]);
    chk("m3 tx frame", {6'h0, 1'b1, t9}, fb[10:9]);
    rd(`SP_IDX_BUF, v); chk("m3 rx byte", e, v);
    rd(`SP_IDX_CTRL, v);
    chk("m3 ctrl", 8'hd3 | {t9, r9, 2'b0}, v);
    wr(`SP_IDX_PWR, 8'h80);
    wr(`SP_IDX_CTRL, 8'h50);
    repeat (2) begin
      q.push_back(rnd());
      u_peer.send({2'b11, q[$], 1'b0}, 10, 32);
    end
    rd(`SP_IDX_BUF, v); chk("overwrite", q[$], v);
    rd(`SP_IDX_CTRL, v); chk("m1 ctrl", 8'h55, v);
    wr(`SP_IDX_PWR, 8'hc0);
    e = rnd();
    u_peer.send({2'b00, e, 1'b0}, 10, 32);
    rd(`SP_IDX_CTRL, v); chk("fe set", 1, v[7]);
    u_peer.send({2'b11, e, 1'b0}, 10, 32);
    rd(`SP_IDX_CTRL, v); chk("fe kept", 1, v[7]);
    wr(`SP_IDX_CTRL, 8'h50);
    rd(`SP_IDX_CTRL, v); chk("fe clear", 8'h50, v);
    wr(`SP_IDX_PWR, 8'h80);
    wr(`SP_IDX_SLAVE_ADDRESS, 8'h56);
    wr(`SP_IDX_SMASK, 8'hfc);
    for (i = 0; i < 6; i++) begin
      wr(`SP_IDX_CTRL, 8'hb0);
      a = i == 0 ? 8'h57 : i == 1 ? 8'hfe : i == 2 ? 8'h54 : rnd();
      t9 = i != 2;
      u_peer.send({1'b1, t9, a, 1'b0}, 11, 32);
      ok = t9 && (((a ^ 8'h56) & 8'hfc) == 0 || (a & 8'hfe) == 8'hfe);
      rd(`SP_IDX_CTRL, v); chk("mp flag", ok, v[0]);
      chk("mp ninth", ok, v[2]);
      rd(`SP_IDX_BUF, v);
      if (ok) chk("mp addr", a, v);
    end
    wr(`SP_IDX_PWR, 8'h00);
    wr(`SP_IDX_CTRL, 8'h90);
    e = rnd();
    u_peer.send({2'b10, e, 1'b0}, 11, 64);
    rd(`SP_IDX_BUF, v); chk("m2 slow byte", e, v);
    end_sim();
  end
endmodule
